// ---- verilog/alarm_fault_map.vh ----
// Register offsets, field positions, reset values and masks for the alarm aggregator.
// Included by the aggregator module; definitions only.
`ifndef ALARM_FAULT_MAP_VH
`define ALARM_FAULT_MAP_VH

// Register offsets on the serial register port
`define ADDR_ALARM_FAULT_MASK     7'h1D
`define ADDR_GENERAL_EVENT_MASK   7'h1E
`define ADDR_ALARM_FAULT_STATUS   7'h20
`define ADDR_GENERAL_STATUS_WORD  7'h21

// Reset values
`define RST_ALARM_FAULT_MASK      16'hEFDF
`define RST_GENERAL_EVENT_MASK    16'hFFFF
`define RST_ALARM_FAULT_STATUS    16'h0200

// Writable bits of the two mask registers; others read as reset value
`define WMASK_ALARM               16'h31FF
`define WMASK_GENERAL             16'h06CF

// Alarm status bit positions
`define BIT_GENERAL_EVENT_SUMMARY 15
`define BIT_SELF_DIAG_FAULT       13
`define BIT_OSC_START_FAILURE     12
`define BIT_CHECKSUM_COUNT_HI     11
`define BIT_CHECKSUM_COUNT_LO     10
`define BIT_TRIM_NOT_LOADED       9
`define BIT_OTP_CRC_ERROR         8
`define BIT_FRAME_CHECKSUM_FAULT  7
`define BIT_WATCHDOG_FAULT        6
`define BIT_REFERENCE_FAULT       5
`define BIT_INPUT_ONE_FAULT       4
`define BIT_INPUT_ZERO_FAULT      3
`define BIT_DIE_TEMP_FAULT        2
`define BIT_OVERTEMP_ERROR        1
`define BIT_OVERTEMP_WARNING      0

// Alarm bits allowed to feed the interrupt (excludes 15, 12, 9 and the count)
`define IRQ_SOURCES_ALARM         16'h21FF

// General status bits that may feed the summary (maskable events)
`define MASKABLE_GENERAL          16'h06CF

// Counter limit above which the count field shows bits 2:1
`define CHECKSUM_LIMIT_SMALL      4'd4

`endif

// ---- verilog/alarm_fault_mask_aggregator.v ----
// Alarm and general event aggregation: status word, masks, interrupt and alarm outputs.
// Assumes a register port decoded by the serial interface and raw fault inputs synchronous
// to i_ref_clk; the general status word itself is built elsewhere and fed in.
`timescale 1ns/1ps
`include "alarm_fault_map.vh"

////////////////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [R1] A set mask bit blocks its fault from interrupt and alarm; clear lets it through. Bits 12, 9 never interrupt, force alarm; bit 15 ignores its mask.
// [R2] Status flags always record their condition, regardless of mask.
// [R3] Alarm mask resets with only oscillator and reference faults unmasked.
// [R4] General mask covers eight events, all masked after reset.
// [R5] Alarm bit 15 is OR of unmasked general status bits.
// [R6] Bit 13 high while any self-diagnostic channel is out of limits.
// [R7] Bit 12 flags oscillator start failure, forces alarm, never interrupts.
// [R8] Count field shows counter bits 1:0 for limit up to four, else 2:1.
// [R9] Bit 9 set from reset until trim loaded once; holds alarm, no interrupt.
// [R10] OTP CRC, checksum and watchdog flags sticky; read clears unless still present.
// [R11] Checksum flag sets on a received frame with bad checksum.
// [R12] Reference flag follows monitor input live, ORed with its force bit.
// [R13] Overtemp error follows 130 C comparator live, ORed with force bit.
// [R14] Overtemp warning follows 85 C comparator live, ORed with force bit.
// [R15] Bits 4, 3, 2 flag input one, input zero, die temperature out of limits.
// [R16] Bit 6 sets when the watchdog reports a fault.
// [R17] General bit 15 is OR of unmasked alarm status bits other than bits 15, 12, 9 and the count.
// [R18] Sticky reads return pre-clear value; events during the read are kept.
module alarm_fault_mask_aggregator (
    input  wire        i_ref_clk,
    input  wire        i_rst,
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    input  wire [6:0]  i_reg_addr,
    input  wire [15:0] i_reg_wdata,
    output reg  [15:0] o_reg_rdata,
    output reg         o_reg_rvalid,
    input  wire        i_self_diag_fault,
    input  wire        i_oscillator_start_failure,
    input  wire [2:0]  i_checksum_fault_count,
    input  wire [3:0]  i_checksum_count_limit,
    input  wire        i_trim_loaded,
    input  wire        i_otp_crc_error,
    input  wire        i_frame_checksum_bad,
    input  wire        i_watchdog_timeout_fault,
    input  wire        i_reference_voltage_fault,
    input  wire        i_input_one_threshold_fault,
    input  wire        i_input_zero_threshold_fault,
    input  wire        i_die_temp_threshold_fault,
    input  wire        i_overtemp_error,
    input  wire        i_overtemp_warning,
    input  wire [2:0]  i_force_fail,
    input  wire [14:0] i_general_status_word,
    output reg         o_general_alarm_summary,
    output reg         o_irq,
    output reg         o_alarm
);

////////////////////////////////////////////////////////////////////////////////////////////
// Registers

reg  [15:0] alarm_fault_mask;
reg  [15:0] general_event_mask;
reg         trim_not_loaded;
reg         otp_crc_sticky;
reg         checksum_sticky;
reg         watchdog_sticky;
reg  [15:0] status_word;
reg  [1:0]  count_field;
reg  [15:0] general_word;
reg         general_summary;
reg         alarm_summary;

wire rd_alarm_status = i_reg_rd && (i_reg_addr == `ADDR_ALARM_FAULT_STATUS);

////////////////////////////////////////////////////////////////////////////////////////////
// Mask registers

// Reserved bits are held at their reset value; only documented fields take writes
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        // [R3] alarm mask reset
        alarm_fault_mask   <= `RST_ALARM_FAULT_MASK;
        // [R4] general mask reset
        general_event_mask <= `RST_GENERAL_EVENT_MASK;
    end else if (i_reg_wr) begin
        if (i_reg_addr == `ADDR_ALARM_FAULT_MASK)
            alarm_fault_mask <= (i_reg_wdata & `WMASK_ALARM) | (`RST_ALARM_FAULT_MASK & ~`WMASK_ALARM);
        if (i_reg_addr == `ADDR_GENERAL_EVENT_MASK)
            general_event_mask <= (i_reg_wdata & `WMASK_GENERAL) | (`RST_GENERAL_EVENT_MASK & ~`WMASK_GENERAL);
    end
end

////////////////////////////////////////////////////////////////////////////////////////////
// Sticky and load-once flags

// A present condition wins over the read clear, so nothing is lost mid-read
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        // [R9] not loaded from reset
        trim_not_loaded <= 1'b1;
        otp_crc_sticky  <= 1'b0;
        checksum_sticky <= 1'b0;
        watchdog_sticky <= 1'b0;
    end else begin
        if (i_trim_loaded)
            trim_not_loaded <= 1'b0;
        // [R10] sticky read clear
        // [R18] set beats clear
        otp_crc_sticky  <= i_otp_crc_error | (otp_crc_sticky & ~rd_alarm_status);
        // [R11] bad frame checksum
        checksum_sticky <= i_frame_checksum_bad | (checksum_sticky & ~rd_alarm_status);
        // [R16] watchdog fault set
        watchdog_sticky <= i_watchdog_timeout_fault | (watchdog_sticky & ~rd_alarm_status);
    end
end

////////////////////////////////////////////////////////////////////////////////////////////
// Status word assembly

// [R8] count field select
always @* begin
    if (i_checksum_count_limit <= `CHECKSUM_LIMIT_SMALL)
        count_field = i_checksum_fault_count[1:0];
    else
        count_field = i_checksum_fault_count[2:1];
end

// General word as seen by the summary; bit 15 is zero here, the alarm side drives it via o_general_alarm_summary
always @* begin
    general_word = {1'b0, i_general_status_word};
    // [R5] unmasked general OR
    general_summary = |(general_word & `MASKABLE_GENERAL & ~general_event_mask);
end

// [R2] flags ignore masks
always @* begin
    status_word = 16'h0000;
    status_word[`BIT_GENERAL_EVENT_SUMMARY] = general_summary;
    // [R6] self diag flag
    status_word[`BIT_SELF_DIAG_FAULT] = i_self_diag_fault;
    // [R7] oscillator failure flag
    status_word[`BIT_OSC_START_FAILURE] = i_oscillator_start_failure;
    status_word[`BIT_CHECKSUM_COUNT_HI:`BIT_CHECKSUM_COUNT_LO] = count_field;
    status_word[`BIT_TRIM_NOT_LOADED] = trim_not_loaded;
    // [R10] sticky or live cause
    // Live term keeps a read in the cause's first cycle from missing it
    status_word[`BIT_OTP_CRC_ERROR] = otp_crc_sticky | i_otp_crc_error;
    status_word[`BIT_FRAME_CHECKSUM_FAULT] = checksum_sticky | i_frame_checksum_bad;
    status_word[`BIT_WATCHDOG_FAULT] = watchdog_sticky | i_watchdog_timeout_fault;
    // [R12] live reference flag
    status_word[`BIT_REFERENCE_FAULT] = i_reference_voltage_fault | i_force_fail[2];
    // [R15] threshold flags
    status_word[`BIT_INPUT_ONE_FAULT] = i_input_one_threshold_fault;
    status_word[`BIT_INPUT_ZERO_FAULT] = i_input_zero_threshold_fault;
    status_word[`BIT_DIE_TEMP_FAULT] = i_die_temp_threshold_fault;
    // [R13] live overtemp error
    status_word[`BIT_OVERTEMP_ERROR] = i_overtemp_error | i_force_fail[1];
    // [R14] live overtemp warning
    status_word[`BIT_OVERTEMP_WARNING] = i_overtemp_warning | i_force_fail[0];
end

// [R1] mask gates propagation
always @* begin
    alarm_summary = |(status_word & `IRQ_SOURCES_ALARM & ~alarm_fault_mask);
end

////////////////////////////////////////////////////////////////////////////////////////////
// Outputs and read port

// Registered outputs; alarm also forced by oscillator failure and missing trim
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_general_alarm_summary <= 1'b0;
        o_irq                   <= 1'b0;
        o_alarm                 <= 1'b1;
    end else begin
        // [R17] alarm summary bit
        o_general_alarm_summary <= alarm_summary;
        // [R1] unmasked faults interrupt
        o_irq                   <= alarm_summary | general_summary;
        // [R7] oscillator holds alarm
        // [R9] trim holds alarm
        o_alarm <= alarm_summary | status_word[`BIT_OSC_START_FAILURE] | trim_not_loaded;
    end
end

// Read data is the pre-clear value, sampled in the read cycle
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_reg_rdata  <= 16'h0000;
        o_reg_rvalid <= 1'b0;
    end else begin
        o_reg_rvalid <= i_reg_rd;
        if (i_reg_rd) begin
            case (i_reg_addr)
                `ADDR_ALARM_FAULT_MASK:   o_reg_rdata <= alarm_fault_mask;
                `ADDR_GENERAL_EVENT_MASK: o_reg_rdata <= general_event_mask;
                // [R18] pre-clear read value
                `ADDR_ALARM_FAULT_STATUS: o_reg_rdata <= status_word;
                default:                  o_reg_rdata <= 16'h0000;
            endcase
        end
    end
end

endmodule

// ---- sim/alarm_fault_checker_assertions.sv ----
// Checker for the alarm aggregator: read port timing and status flag contents.
// Assumes it is bound onto the aggregator top and sees its ports only.
`timescale 1ns/1ps
`include "alarm_fault_map.vh"
module alarm_fault_checker (
    input wire        i_ref_clk,
    input wire        i_rst,
    input wire        i_reg_rd,
    input wire [6:0]  i_reg_addr,
    input wire [15:0] o_reg_rdata,
    input wire        o_reg_rvalid,
    input wire        i_self_diag_fault,
    input wire        i_oscillator_start_failure,
    input wire        i_frame_checksum_bad,
    input wire        i_watchdog_timeout_fault,
    input wire        i_reference_voltage_fault,
    input wire        i_input_one_threshold_fault,
    input wire        i_input_zero_threshold_fault,
    input wire        i_die_temp_threshold_fault,
    input wire        i_overtemp_error,
    input wire        i_overtemp_warning,
    input wire [2:0]  i_force_fail,
    input wire        o_alarm
);
    // Status register read strobe
    wire rd_st = i_reg_rd && (i_reg_addr == `ADDR_ALARM_FAULT_STATUS);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////////////
    a_rvalid_after_read: assert property (i_reg_rd |=> o_reg_rvalid) else $error("no rvalid");
    a_rvalid_no_read: assert property (!i_reg_rd |=> !o_reg_rvalid) else $error("stray rvalid");
    a_osc_holds_alarm: assert property (i_oscillator_start_failure |=> o_alarm) else $error("alarm low");
    a_ref_flag_live: assert property (rd_st |=> o_reg_rdata[5] ==
        ($past(i_reference_voltage_fault) | $past(i_force_fail[2]))) else $error("bit 5 wrong");
    a_diag_flag_live: assert property (rd_st |=> o_reg_rdata[13] == $past(i_self_diag_fault))
        else $error("bit 13 wrong");
    a_threshold_flags_live: assert property (rd_st |=> o_reg_rdata[4:2] ==
        {$past(i_input_one_threshold_fault), $past(i_input_zero_threshold_fault),
         $past(i_die_temp_threshold_fault)}) else $error("bits 4:2 wrong");
    a_temp_error_live: assert property (rd_st |=> o_reg_rdata[1] ==
        ($past(i_overtemp_error) | $past(i_force_fail[1]))) else $error("bit 1 wrong");
    a_temp_warn_live: assert property (rd_st |=> o_reg_rdata[0] ==
        ($past(i_overtemp_warning) | $past(i_force_fail[0]))) else $error("bit 0 wrong");
    a_watchdog_flag_set: assert property (rd_st && i_watchdog_timeout_fault |=> o_reg_rdata[6])
        else $error("bit 6 clear");
    a_frame_flag_set: assert property (i_frame_checksum_bad ##1 rd_st |=> o_reg_rdata[7])
        else $error("bit 7 clear");
endmodule
bind alarm_fault_mask_aggregator alarm_fault_checker u_chk (.*);

// ---- sim/alarm_fault_mask_aggregator_test.sv ----
// Bench for the alarm aggregator: strobe register tasks, fault drive, flag and output checks.
// Assumes the aggregator's strobe register port and one 200 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module alarm_fault_mask_aggregator_test;
    reg         clk = 0, rst = 1, rd = 0, wr = 0, trim = 0;
    reg  [6:0]  addr = 0;
    reg  [15:0] wdat = 0, src = 0;
    reg  [14:0] gen = 0;
    reg  [2:0]  cnt = 0, ff = 0;
    reg  [3:0]  lim = 4'h4;
    wire [15:0] rdata;
    wire        rvalid, summ, irq, alarm;
    integer     mismatches = 0, check_count = 0, cycles = 0, i;
    alarm_fault_mask_aggregator DUT (.i_ref_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdat), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_self_diag_fault(src[13]), .i_oscillator_start_failure(src[12]), .i_checksum_fault_count(cnt),
        .i_checksum_count_limit(lim), .i_trim_loaded(trim), .i_otp_crc_error(src[8]),
        .i_frame_checksum_bad(src[7]), .i_watchdog_timeout_fault(src[6]), .i_reference_voltage_fault(src[5]),
        .i_input_one_threshold_fault(src[4]), .i_input_zero_threshold_fault(src[3]),
        .i_die_temp_threshold_fault(src[2]), .i_overtemp_error(src[1]), .i_overtemp_warning(src[0]),
        .i_force_fail(ff), .i_general_status_word(gen), .o_general_alarm_summary(summ), .o_irq(irq),
        .o_alarm(alarm));
    // 200 MHz clock and hang guard
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            stop_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, mismatches);
            if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task wreg(input [6:0] a, input [15:0] d);
        begin
            addr <= a;
            wdat <= d;
            wr <= 1'b1;
            tick(1);
            wr <= 1'b0;
            tick(1);
        end
    endtask
    // Read strobe, then look at rvalid and data once the answer edge has landed
    task rreg(input [6:0] a, input [15:0] e);
        begin
            addr <= a;
            rd <= 1'b1;
            tick(1);
            rd <= 1'b0;
            #1 `CHK(rvalid, 1'b1)
            `CHK(rdata, e)
            tick(1);
        end
    endtask
    task outs(input q, input al, input s);
        begin
            #1 `CHK(irq, q)
            `CHK(alarm, al)
            `CHK(summ, s)
            tick(1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(12);
        rst <= 1'b0;
        tick(1);
        rreg(7'h1D, 16'hEFDF);
        rreg(7'h1E, 16'hFFFF);
        rreg(7'h20, 16'h0200);
        outs(1'b0, 1'b1, 1'b0);
        trim <= 1'b1;
        tick(1);
        trim <= 1'b0;
        tick(2);
        rreg(7'h20, 16'h0000);
        // Each live source but bit 12: flagged while masked (bit 5 is unmasked from reset), reaches outputs once unmasked
        for (i = 0; i < 14; i++) if (i < 6 || i == 13) begin
            src[i] <= 1'b1;
            tick(2);
            rreg(7'h20, 16'h0001 << i);
            outs(i == 5, i == 5, i == 5);
            wreg(7'h1D, ~(16'h0001 << i));
            tick(2);
            outs(1'b1, 1'b1, 1'b1);
            src[i] <= 1'b0;
            wreg(7'h1D, 16'hEFDF);
            tick(2);
        end
        ff <= 3'b111;
        tick(2);
        rreg(7'h20, 16'h0023);
        ff <= 3'b000;
        wreg(7'h1D, 16'h0000);
        src[12] <= 1'b1;
        tick(2);
        rreg(7'h1D, 16'hCE00);
        rreg(7'h20, 16'h1000);
        outs(1'b0, 1'b1, 1'b0);
        src[12] <= 1'b0;
        src[8:6] <= 3'b111;
        tick(1);
        src[8:6] <= 3'b000;
        rreg(7'h20, 16'h01C0);
        rreg(7'h20, 16'h0000);
        src[6] <= 1'b1;
        tick(1);
        rreg(7'h20, 16'h0040);
        src[6] <= 1'b0;
        rreg(7'h20, 16'h0040);
        cnt <= 3'b110;
        tick(1);
        rreg(7'h20, 16'h0800);
        lim <= 4'h8;
        tick(1);
        rreg(7'h20, 16'h0C00);
        cnt <= 3'b000;
        gen <= 15'h0400;
        tick(2);
        rreg(7'h20, 16'h0000);
        wreg(7'h1E, 16'hFBFF);
        tick(2);
        rreg(7'h20, 16'h8000);
        outs(1'b1, 1'b0, 1'b0);
        wreg(7'h1E, 16'h0000);
        rreg(7'h1E, 16'hF930);
        gen <= 15'h0000;
        src[0] <= 1'b1;
        tick(2);
        outs(1'b1, 1'b1, 1'b1);
        wreg(7'h1D, 16'hFFFF);
        tick(2);
        outs(1'b0, 1'b0, 1'b0);
        wreg(7'h20, 16'hFFFF);
        wreg(7'h55, 16'hFFFF);
        rreg(7'h55, 16'h0000);
        rreg(7'h20, 16'h0001);
        stop_test;
    end
endmodule
